// ===== core/spcs_top.sv
// serial port configuration, status and shift engine
`timescale 1ns/1ps
// Functional notes
// - The transfer-active bit reads 1 while a transfer runs in either mode.
// - The master-select bit set to 1 makes the port a master, 0 a slave.
// - Phase 0 centres data on the first clock edge, phase 1 on the second.
// - Polarity 0 idles the serial clock low, polarity 1 idles it high.
// - The selected flag is 1 while the de-glitched select is low.
// - The raw select bit reads the unfiltered select level at the read.
// - The shifter-empty bit sets once nothing is shifting or pending.
// - Shifter-empty clears on a load from the transmit buffer or a clock edge.
// - Receive-holding-empty sets after a read and clears on new data.
// - A slave samples the incoming data in the centre of each bit.
// - A master samples its input at the end of each bit.
// - A four-wire slave joins transfers only while select is low.
// - Both ends must use the same phase and polarity settings.
module spcs_top (
  input  wire logic       sys_clk,        // system clock
  input  wire logic       rst_n,          // synchronous reset, active low
  input  wire logic [7:0] sfrAddr,        // register address
  input  wire logic [7:0] sfrWrData,      // register write data
  input  wire logic       sfrWr,          // register write strobe
  input  wire logic       sfrRd,          // register read strobe
  output logic      [7:0] sfrRdData,      // register read data
  input  wire logic       blockEnable,    // port enable from control
  input  wire logic [7:0] txData,         // transmit byte
  input  wire logic       txWrite,        // transmit buffer write strobe
  output logic            txBufEmpty,     // transmit buffer free
  output logic      [7:0] rxData,         // received byte
  input  wire logic       rxRead,         // receive buffer read strobe
  output logic            transferDone,   // byte complete pulse
  input  wire logic       sckIn,          // serial clock pin level
  output logic            sckOut,         // serial clock drive
  output logic            sckOe,          // serial clock enable
  input  wire logic       mosiIn,         // master out pin level
  output logic            mosiOut,        // master out drive
  output logic            mosiOe,         // master out enable
  input  wire logic       misoIn,         // master in pin level
  output logic            misoOut,        // master in drive
  output logic            misoOe,         // master in enable
  input  wire logic       slaveSelectNIn  // slave select pin, active low
);
  import spcs_pkg::*;

  spcs_pin_if pinBus ();

  spcs_pin_sync u_sync (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .sckPin     (sckIn),
    .mosiPin    (mosiIn),
    .misoPin    (misoIn),
    .selectNPin (slaveSelectNIn),
    .syncOut    (pinBus)
  );

  // configuration register address decode
  function automatic logic cfgHit(input logic [7:0] addr);
    cfgHit = (addr == CFG_ADDR);
  endfunction

  logic [2:0]  cfgReg;
  logic [2:0]  cfgNext;
  logic [7:0]  rdDataReg;
  logic [7:0]  rdDataNext;
  logic        masterSel;
  logic        phaseSel;
  logic        polSel;
  spcs_state_e stateReg;
  spcs_state_e stateNext;
  spcs_cyc_t   cycReg;
  spcs_cyc_t   cycNext;
  spcs_bit_t   bitReg;
  spcs_bit_t   bitNext;
  logic [7:0]  shiftReg;
  logic [7:0]  shiftNext;
  logic [7:0]  rxShiftReg;
  logic [7:0]  rxShiftNext;
  logic [7:0]  txBufReg;
  logic [7:0]  txBufNext;
  logic        txFullReg;
  logic        txFullNext;
  logic [7:0]  rxBufReg;
  logic [7:0]  rxBufNext;
  logic        rxFullReg;
  logic        rxFullNext;
  logic        srmtReg;
  logic        srmtNext;
  logic        doneReg;
  logic        doneNext;
  logic        outBitReg;
  logic        outBitNext;
  logic        sckPrevReg;
  logic        selPrevReg;
  logic        sckOutReg;
  logic        sckOutNext;
  logic        sckOeReg;
  logic        sckOeNext;
  logic        mosiOeReg;
  logic        misoOeReg;
  logic        misoOeNext;
  logic        slvSelected;
  logic        sckLead;
  logic        sckTrail;
  logic        sampleEdge;
  logic        shiftEdge;
  logic        loadNow;
  logic        sckEdge;

  assign masterSel = cfgReg[2];
  assign phaseSel  = cfgReg[1];
  assign polSel    = cfgReg[0];

  // configuration write and status read
  always_comb
  begin
    cfgNext    = cfgReg;
    rdDataNext = 8'h00;
    if (sfrWr && cfgHit(sfrAddr))
      cfgNext = {sfrWrData[MSTR_BIT], sfrWrData[PHA_BIT],
                 sfrWrData[POL_BIT]};
    if (sfrRd && cfgHit(sfrAddr))
    begin
      rdDataNext[BUSY_BIT] = (stateReg != SPCS_IDLE);
      rdDataNext[MSTR_BIT] = masterSel;
      rdDataNext[PHA_BIT]  = phaseSel;
      rdDataNext[POL_BIT]  = polSel;
      rdDataNext[SEL_BIT]  = !pinBus.ssnFilt;
      rdDataNext[RAW_BIT]  = pinBus.ssnRaw;
      rdDataNext[SHIFTER_EMPTY_BIT] = srmtReg;
      rdDataNext[RXE_BIT]  = !rxFullReg;
    end
  end

  // register bus state
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cfgReg    <= {MSTR_RESET, PHA_RESET, POL_RESET};
      rdDataReg <= 8'h00;
    end
    else
    begin
      cfgReg    <= cfgNext;
      rdDataReg <= rdDataNext;
    end
  end

  // slave clock edges relative to the idle level
  assign slvSelected = !pinBus.ssnFilt && !masterSel && blockEnable;
  assign sckLead  = (pinBus.sckS != sckPrevReg) && (pinBus.sckS != polSel);
  assign sckTrail = (pinBus.sckS != sckPrevReg) && (pinBus.sckS == polSel);
  assign sampleEdge = phaseSel ? sckTrail : sckLead;
  assign shiftEdge  = phaseSel ? sckLead : sckTrail;

  // shift engine next state
  always_comb
  begin
    stateNext   = stateReg;
    cycNext     = cycReg;
    bitNext     = bitReg;
    shiftNext   = shiftReg;
    rxShiftNext = rxShiftReg;
    txBufNext   = txBufReg;
    txFullNext  = txFullReg;
    rxBufNext   = rxBufReg;
    rxFullNext  = rxFullReg;
    srmtNext    = srmtReg;
    outBitNext  = outBitReg;
    doneNext    = 1'b0;
    loadNow     = 1'b0;
    sckEdge     = 1'b0;
    if (rxRead)
      rxFullNext = 1'b0;
    if (!blockEnable)
    begin
      stateNext = SPCS_IDLE;
      cycNext   = '0;
      bitNext   = '0;
    end
    else if (masterSel)
    begin
      if (stateReg == SPCS_MRUN)
      begin
        cycNext = spcs_cyc_t'(cycReg + 2'h1);
        if (cycReg == spcs_cyc_t'(BIT_CYC - 1))
        begin
          rxShiftNext = {rxShiftReg[6:0], pinBus.misoS};
          outBitNext  = shiftReg[6];
          shiftNext   = {shiftReg[6:0], 1'b0};
          bitNext     = spcs_bit_t'(bitReg + 4'h1);
          if (bitReg == spcs_bit_t'(BYTE_BITS - 1))
          begin
            doneNext   = 1'b1;
            rxBufNext  = {rxShiftReg[6:0], pinBus.misoS};
            rxFullNext = 1'b1;
            bitNext    = '0;
            stateNext  = SPCS_IDLE;
          end
        end
      end
      else if (txFullReg)
      begin
        loadNow    = 1'b1;
        shiftNext  = txBufReg;
        outBitNext = txBufReg[7];
        txFullNext = 1'b0;
        stateNext  = SPCS_MRUN;
        cycNext    = '0;
        bitNext    = '0;
      end
    end
    else if (!slvSelected)
    begin
      stateNext = SPCS_IDLE;
      bitNext   = '0;
    end
    else if (!selPrevReg)
    begin // fresh selection resets the bit count and preloads
      bitNext = '0;
      if (txFullReg)
      begin
        loadNow    = 1'b1;
        shiftNext  = txBufReg;
        outBitNext = txBufReg[7];
        txFullNext = 1'b0;
      end
    end
    else if (sckLead || sckTrail)
    begin
      sckEdge   = 1'b1;
      stateNext = SPCS_SRUN;
      if (shiftEdge)
      begin
        if (!phaseSel && bitReg == '0)
        begin // byte boundary for phase 0
          if (txFullReg)
          begin
            loadNow    = 1'b1;
            shiftNext  = txBufReg;
            outBitNext = txBufReg[7];
            txFullNext = 1'b0;
          end
          stateNext = SPCS_IDLE;
        end
        else
        begin
          outBitNext = phaseSel ? shiftReg[7] : shiftReg[6];
          shiftNext  = {shiftReg[6:0], 1'b0};
        end
      end
      if (sampleEdge)
      begin
        rxShiftNext = {rxShiftReg[6:0], pinBus.mosiS};
        bitNext     = spcs_bit_t'(bitReg + 4'h1);
        if (bitReg == spcs_bit_t'(BYTE_BITS - 1))
        begin
          doneNext   = 1'b1;
          rxBufNext  = {rxShiftReg[6:0], pinBus.mosiS};
          rxFullNext = 1'b1;
          bitNext    = '0;
          stateNext  = phaseSel ? SPCS_IDLE : SPCS_SRUN;
          if (phaseSel && txFullReg)
          begin
            loadNow    = 1'b1;
            shiftNext  = txBufReg;
            txFullNext = 1'b0;
          end
        end
      end
    end
    if (txWrite && !txFullReg)
    begin
      txBufNext  = txData;
      txFullNext = 1'b1;
    end
    if (loadNow || sckEdge)
      srmtNext = 1'b0;
    else if (stateNext == SPCS_IDLE && !txFullReg && bitNext == '0)
      srmtNext = 1'b1;
    if (stateNext == SPCS_MRUN)
      sckOutNext = polSel ^ (phaseSel ? (cycNext < spcs_cyc_t'(HALF_CYC))
                                      : (cycNext >= spcs_cyc_t'(HALF_CYC)));
    else
      sckOutNext = polSel;
    sckOeNext  = masterSel && blockEnable;
    misoOeNext = slvSelected;
  end

  // shift engine registers
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      stateReg   <= SPCS_IDLE;
      cycReg     <= '0;
      bitReg     <= '0;
      shiftReg   <= 8'h00;
      rxShiftReg <= 8'h00;
      txBufReg   <= 8'h00;
      txFullReg  <= 1'b0;
      rxBufReg   <= 8'h00;
      rxFullReg  <= 1'b0;
      srmtReg    <= SHIFTER_EMPTY_RESET;
      doneReg    <= 1'b0;
      outBitReg  <= 1'b0;
      sckPrevReg <= POL_RESET;
      selPrevReg <= 1'b0;
      sckOutReg  <= POL_RESET;
      sckOeReg   <= 1'b0;
      mosiOeReg  <= 1'b0;
      misoOeReg  <= 1'b0;
    end
    else
    begin
      stateReg   <= stateNext;
      cycReg     <= cycNext;
      bitReg     <= bitNext;
      shiftReg   <= shiftNext;
      rxShiftReg <= rxShiftNext;
      txBufReg   <= txBufNext;
      txFullReg  <= txFullNext;
      rxBufReg   <= rxBufNext;
      rxFullReg  <= rxFullNext;
      srmtReg    <= srmtNext;
      doneReg    <= doneNext;
      outBitReg  <= outBitNext;
      sckPrevReg <= pinBus.sckS;
      selPrevReg <= slvSelected;
      sckOutReg  <= sckOutNext;
      sckOeReg   <= sckOeNext;
      mosiOeReg  <= sckOeNext;
      misoOeReg  <= misoOeNext;
    end
  end

  // outputs straight from registers
  assign sfrRdData    = rdDataReg;
  assign txBufEmpty   = !txFullReg;
  assign rxData       = rxBufReg;
  assign transferDone = doneReg;
  assign sckOut       = sckOutReg;
  assign sckOe        = sckOeReg;
  assign mosiOut      = outBitReg;
  assign mosiOe       = mosiOeReg;
  assign misoOut      = outBitReg;
  assign misoOe       = misoOeReg;

  property p_busy_read;
    @(posedge sys_clk) disable iff (!rst_n)
    (sfrRd && cfgHit(sfrAddr)) |=>
      (sfrRdData[BUSY_BIT] == ($past(stateReg) != SPCS_IDLE));
  endproperty
  a_busy_read: assert property (p_busy_read)
    else $error("busy bit does not follow transfer state");

  property p_master_drive;
    @(posedge sys_clk) disable iff (!rst_n)
    ##1 (sckOe == $past(masterSel && blockEnable)) && (mosiOe == sckOe);
  endproperty
  a_master_drive: assert property (p_master_drive)
    else $error("clock drive does not follow master select");

  property p_mid_edge;
    @(posedge sys_clk) disable iff (!rst_n)
    (stateReg == SPCS_MRUN && cycReg == spcs_cyc_t'(HALF_CYC)
      && $stable(cfgReg)) |-> (sckOut == (polSel ^ !phaseSel));
  endproperty
  a_mid_edge: assert property (p_mid_edge)
    else $error("serial clock wrong at mid bit");

  property p_idle_pol;
    @(posedge sys_clk) disable iff (!rst_n)
    (stateReg == SPCS_IDLE && $past(stateNext) == SPCS_IDLE
      && $stable(polSel)) |-> (sckOut == polSel);
  endproperty
  a_idle_pol: assert property (p_idle_pol)
    else $error("idle serial clock level wrong");

  property p_sel_read;
    @(posedge sys_clk) disable iff (!rst_n)
    (sfrRd && cfgHit(sfrAddr)) |=>
      (sfrRdData[SEL_BIT] == !$past(pinBus.ssnFilt))
      && (sfrRdData[RAW_BIT] == $past(pinBus.ssnRaw));
  endproperty
  a_sel_read: assert property (p_sel_read)
    else $error("select bits read wrong");

  property p_load_shifter_empty;
    @(posedge sys_clk) disable iff (!rst_n)
    ((txFullReg && !txFullNext)
      || (slvSelected && selPrevReg && pinBus.sckS != sckPrevReg)) |=> !srmtReg;
  endproperty
  a_load_shifter_empty: assert property (p_load_shifter_empty)
    else $error("shifter empty not cleared");

  property p_rx_flag;
    @(posedge sys_clk) disable iff (!rst_n)
    doneNext |=> (rxFullReg && transferDone) ##1 !transferDone;
  endproperty
  a_rx_flag: assert property (p_rx_flag)
    else $error("received byte not flagged");

  property p_master_sample;
    @(posedge sys_clk) disable iff (!rst_n)
    (blockEnable && masterSel && stateReg == SPCS_MRUN
      && cycReg == spcs_cyc_t'(BIT_CYC - 1)) |=>
      (rxShiftReg[0] == $past(pinBus.misoS));
  endproperty
  a_master_sample: assert property (p_master_sample)
    else $error("master input not sampled at bit end");

  property p_slave_ignore;
    @(posedge sys_clk) disable iff (!rst_n)
    (!masterSel && pinBus.ssnFilt) |=> (stateReg == SPCS_IDLE) && !misoOe;
  endproperty
  a_slave_ignore: assert property (p_slave_ignore)
    else $error("deselected slave took part in a transfer");

  property p_cfg_write;
    @(posedge sys_clk) disable iff (!rst_n)
    (sfrWr && cfgHit(sfrAddr)) |=> (cfgReg == {$past(sfrWrData[MSTR_BIT]),
      $past(sfrWrData[PHA_BIT]), $past(sfrWrData[POL_BIT])});
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("configuration write stored wrong bits");
endmodule

// ===== core/spcs_pkg.sv
// shared constants and types for the serial port configuration block
package spcs_pkg;
  // register address and field positions
  localparam logic [7:0] CFG_ADDR = 8'ha1;
  localparam int BUSY_BIT = 7;
  localparam int MSTR_BIT = 6;
  localparam int PHA_BIT  = 5;
  localparam int POL_BIT  = 4;
  localparam int SEL_BIT  = 3;
  localparam int RAW_BIT  = 2;
  localparam int SHIFTER_EMPTY_BIT = 1;
  localparam int RXE_BIT  = 0;
  // reset values
  localparam logic       MSTR_RESET = 1'b0;
  localparam logic       PHA_RESET  = 1'b0;
  localparam logic       POL_RESET  = 1'b0;
  localparam logic       SHIFTER_EMPTY_RESET = 1'b1;
  localparam logic [3:0] PIN_RESET  = 4'h8; // select high, others low
  // timing counts in system clock cycles
  localparam int HALF_CYC = 2;              // master serial clock half period
  localparam int BIT_CYC  = 2 * HALF_CYC;   // master bit period
  localparam int FILT_LEN = 4;              // select de-glitch length
  localparam int BYTE_BITS = 8;
  typedef logic [1:0] spcs_cyc_t;
  typedef logic [3:0] spcs_bit_t;
  typedef logic [2:0] spcs_filt_t;
  typedef enum logic [1:0] {SPCS_IDLE, SPCS_MRUN, SPCS_SRUN} spcs_state_e;
endpackage

// ===== core/spcs_pin_if.sv
// synchronised pin levels passed from the pin synchroniser to the engine
`timescale 1ns/1ps
interface spcs_pin_if;
  logic sckS;    // serial clock, synchronised
  logic mosiS;   // master out data, synchronised
  logic misoS;   // master in data, synchronised
  logic ssnRaw;  // select pin, synchronised, not de-glitched
  logic ssnFilt; // select pin, de-glitched
  modport src (output sckS, mosiS, misoS, ssnRaw, ssnFilt);
  modport dst (input sckS, mosiS, misoS, ssnRaw, ssnFilt);
endinterface

// ===== core/spcs_pin_sync.sv
// three-stage pin synchroniser with select de-glitch filter
`timescale 1ns/1ps
module spcs_pin_sync (
  input wire logic  sys_clk,    // system clock
  input wire logic  rst_n,      // synchronous reset, active low
  input wire logic  sckPin,     // serial clock pin
  input wire logic  mosiPin,    // master out pin
  input wire logic  misoPin,    // master in pin
  input wire logic  selectNPin, // slave select pin, active low
  spcs_pin_if.src   syncOut     // synchronised levels
);
  import spcs_pkg::*;

  logic [3:0] pinIn;
  logic [3:0] st1Reg;
  logic [3:0] st2Reg;
  logic [3:0] st3Reg;
  logic [3:0] cleanReg;
  logic [3:0] cleanNext;
  logic       filtReg;
  logic       filtNext;
  spcs_filt_t cntReg;
  spcs_filt_t cntNext;

  assign pinIn = {selectNPin, misoPin, mosiPin, sckPin};

  // a change counts once stages two and three agree
  always_comb
  begin
    cleanNext = ((st2Reg ~^ st3Reg) & st3Reg) | ((st2Reg ^ st3Reg) & cleanReg);
    filtNext  = filtReg;
    cntNext   = '0;
    if (cleanReg[3] != filtReg)
    begin
      if (cntReg == spcs_filt_t'(FILT_LEN - 1))
        filtNext = cleanReg[3];
      else
        cntNext = spcs_filt_t'(cntReg + 3'h1);
    end
  end

  // register stages
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st1Reg   <= PIN_RESET;
      st2Reg   <= PIN_RESET;
      st3Reg   <= PIN_RESET;
      cleanReg <= PIN_RESET;
      filtReg  <= 1'b1;
      cntReg   <= '0;
    end
    else
    begin
      st1Reg   <= pinIn;
      st2Reg   <= st1Reg;
      st3Reg   <= st2Reg;
      cleanReg <= cleanNext;
      filtReg  <= filtNext;
      cntReg   <= cntNext;
    end
  end

  // clock and data take the agreed level at once, saving a cycle that a
  // short serial half period cannot spare; select uses the held copy
  assign syncOut.sckS    = cleanNext[0];
  assign syncOut.mosiS   = cleanNext[1];
  assign syncOut.misoS   = cleanNext[2];
  assign syncOut.ssnRaw  = cleanReg[3];
  assign syncOut.ssnFilt = filtReg;

  // filtered select only moves after a steady run of the new level
  property p_filt_steady;
    @(posedge sys_clk) disable iff (!rst_n)
    $changed(filtReg) |-> ($past(cleanReg[3], 1) == filtReg)
      && ($past(cleanReg[3], 2) == filtReg)
      && ($past(cleanReg[3], 3) == filtReg);
  endproperty
  a_filt_steady: assert property (p_filt_steady)
    else $error("select filter changed without a steady input");
endmodule

// ===== tb/spcs_far_end.sv
// far-end model: slave to a master port, master to a slave port
`timescale 1ns/1ps
module spcs_far_end (
  input  wire logic sckLine,  // resolved serial clock
  input  wire logic mosiLine, // resolved master out line
  input  wire logic misoLine, // resolved master in line
  output logic      sckDrv,   // clock drive as master
  output logic      mosiDrv,  // data drive as master
  output logic      misoDrv,  // data drive as slave
  output logic      selectN   // select drive, active low
);
  logic       slvOn;  // slave role armed
  logic       slvPha; // slave phase
  logic       slvPol; // slave polarity
  logic [7:0] slvSh;  // slave shift register
  logic [7:0] slvRx;  // byte taken as slave
  logic [7:0] mstRx;  // byte taken as master
  // idle levels
  initial
  begin
    slvOn = 1'b0;
    sckDrv = 1'b0;
    mosiDrv = 1'b0;
    misoDrv = 1'b0;
    selectN = 1'b1;
  end
  // arm the slave; phase 0 shows the first bit before any edge
  task automatic slaveArm(input logic [7:0] d, input logic pha, pol);
    slvPha = pha;
    slvPol = pol;
    slvSh = pha ? d : {d[6:0], 1'b0};
    misoDrv = pha ? ~d[7] : d[7];
    slvOn = 1'b1;
  endtask
  // release the slave; a released line shows the inverse level
  task automatic slaveOff;
    slvOn = 1'b0;
    misoDrv = ~misoDrv;
  endtask
  // slave role: sample on one edge, shift on the other
  always @(sckLine)
  begin
    if (slvOn && ((sckLine != slvPol) != slvPha))
      slvRx = {slvRx[6:0], mosiLine};
    else if (slvOn)
    begin
      misoDrv = slvSh[7];
      slvSh = slvSh << 1;
    end
  end
  // master role: one framed byte, clock still outside the frame
  task automatic mxfer(input logic [7:0] d, input logic pha, pol);
    sckDrv = pol;
    selectN = 1'b0;
    mosiDrv = d[7];
    #100;
    for (int i = 0; i < 8; i++)
    begin
      #24;
      // phase 1 data moves with the leading edge
      if (!pha)
        mstRx = {mstRx[6:0], misoLine};
      else
        mosiDrv = d[7-i];
      sckDrv = ~pol;
      #24;
      if (pha)
        mstRx = {mstRx[6:0], misoLine};
      else if (i < 7)
        mosiDrv = d[6-i];
      sckDrv = pol;
    end
    #100;
    selectN = 1'b1;
    mosiDrv = ~mosiDrv;
  endtask
  // clock pulses with select high, which the port must ignore
  task automatic strayClocks;
    repeat (16) #24 sckDrv = ~sckDrv;
  endtask
endmodule

// ===== tb/spi_config_status_tb.sv
// self-checking bench for the serial port configuration block
`timescale 1ns/1ps
module spi_config_status_tb;
  import spcs_pkg::*;
  logic        sys_clk, rst_n, sfrWr, sfrRd, blockEnable;
  logic        txWrite, rxRead, rdLast, txBufEmpty, transferDone;
  logic        sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe;
  logic        sckDrv, mosiDrv, misoDrv, selectN;
  logic        sckLine, mosiLine, misoLine;
  logic [7:0]  sfrAddr, sfrWrData, sfrRdData, txData, rxData;
  logic [7:0]  cfgV, a, b;
  logic [15:0] note;
  int          mismatches, checks;
  logic [7:0]  expRx[$];
  logic [15:0] expRd[$];
  // wire levels from the port's enables; the far end drives whenever the port does not
  assign sckLine  = sckOe ? sckOut : sckDrv;
  assign mosiLine = mosiOe ? mosiOut : mosiDrv;
  assign misoLine = misoOe ? misoOut : misoDrv;
  spcs_top dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .sfrAddr(sfrAddr),
    .sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRd(sfrRd),
    .sfrRdData(sfrRdData), .blockEnable(blockEnable), .txData(txData),
    .txWrite(txWrite), .txBufEmpty(txBufEmpty), .rxData(rxData),
    .rxRead(rxRead), .transferDone(transferDone), .sckIn(sckLine),
    .sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiLine),
    .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoLine),
    .misoOut(misoOut), .misoOe(misoOe), .slaveSelectNIn(selectN)
  );
  spcs_far_end far (
    .sckLine(sckLine), .mosiLine(mosiLine), .misoLine(misoLine),
    .sckDrv(sckDrv), .mosiDrv(mosiDrv), .misoDrv(misoDrv),
    .selectN(selectN)
  );
  // system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // compare one value, count and report
  task automatic check(input string what, input logic [7:0] e, s);
    checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask
  // counts and verdict, then stop
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // register write
  task automatic wrReg(input logic [7:0] ad, d);
    @(negedge sys_clk);
    sfrAddr = ad;
    sfrWrData = d;
    sfrWr = 1'b1;
    @(negedge sys_clk);
    sfrWr = 1'b0;
  endtask
  // register read; expected value and mask noted for the monitor
  task automatic rdReg(input logic [7:0] ad, e, m);
    expRd.push_back({e, m});
    @(negedge sys_clk);
    sfrAddr = ad;
    sfrRd = 1'b1;
    @(negedge sys_clk);
    sfrRd = 1'b0;
  endtask
  // transmit buffer write
  task automatic wrTx(input logic [7:0] d);
    @(negedge sys_clk);
    txData = d;
    txWrite = 1'b1;
    @(negedge sys_clk);
    txWrite = 1'b0;
  endtask
  // bounded wait until every note is consumed
  task automatic waitQ;
    int n;
    for (n = 0; n < 3000; n++)
    begin
      if (expRx.size() == 0 && expRd.size() == 0)
        break;
      @(negedge sys_clk);
    end
    if (n == 3000)
    begin
      mismatches++;
      $display("[FAIL] wait expected 0 seen %0d", n);
      test_done();
    end
  endtask
  // read strobe taken at the rising edge
  always @(posedge sys_clk)
    rdLast <= sfrRd;
  // monitor: oldest note against each result
  always @(negedge sys_clk)
  begin
    if (transferDone === 1'b1 && expRx.size() == 0)
    begin
      mismatches++;
      $display("[FAIL] byte done expected none seen %h", rxData);
    end
    else if (transferDone === 1'b1)
      check("rxData", expRx.pop_front(), rxData);
    if (rdLast === 1'b1)
    begin
      note = expRd.pop_front();
      note[15:8] = note[15:8] & note[7:0];
      check("status", note[15:8], sfrRdData & note[7:0]);
    end
  end
  // main sequence
  initial
  begin
    {sfrWr, sfrRd, txWrite, rxRead, blockEnable} = 5'h00;
    {sfrAddr, sfrWrData, txData} = {8'h00, 8'h00, 8'h00};
    rst_n = 1'b0;
    void'($urandom(31));
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    rdReg(CFG_ADDR, 8'h07, 8'hff);
    rdReg(8'ha0, 8'h00, 8'hff);
    wrReg(CFG_ADDR, 8'hff);
    wrReg(8'ha2, 8'h00);
    rdReg(CFG_ADDR, 8'h77, 8'hff);
    waitQ();
    $display("test register access done");
    for (int m = 0; m < 8; m++)
    begin
      cfgV = {1'b0, ~m[2], m[1], m[0], 4'h0};
      @(negedge sys_clk);
      blockEnable = 1'b0;
      far.sckDrv = m[0];
      wrReg(CFG_ADDR, cfgV);
      @(negedge sys_clk);
      blockEnable = 1'b1;
      repeat (4) @(negedge sys_clk);
      a = 8'($urandom);
      b = 8'($urandom);
      if (!m[2])
      begin
        check("sckOut idle", {7'h00, m[0]}, {7'h00, sckOut});
        far.slaveArm(b, m[1], m[0]);
        expRx.push_back(b);
        wrTx(a);
        repeat (8) @(negedge sys_clk);
        rdReg(CFG_ADDR, 8'h80 | cfgV, 8'hf2);
        waitQ();
        check("far slave byte", a, far.slvRx);
        far.slaveOff();
      end
      else
      begin
        if (m == 4)
        begin
          far.strayClocks();
          repeat (20) @(negedge sys_clk);
          check("misoOe unselected", 8'h00, {7'h00, misoOe});
        end
        wrTx(a);
        check("txBufEmpty held", 8'h00, {7'h00, txBufEmpty});
        expRx.push_back(b);
        fork
          far.mxfer(b, m[1], m[0]);
          begin
            repeat (14) @(negedge sys_clk);
            rdReg(CFG_ADDR, 8'h08 | cfgV, 8'hfc);
            check("misoOe selected", 8'h01, {7'h00, misoOe});
          end
        join
        waitQ();
        check("far master byte", a, far.mstRx);
      end
      repeat (10) @(negedge sys_clk);
      check("txBufEmpty free", 8'h01, {7'h00, txBufEmpty});
      rdReg(CFG_ADDR, 8'h06 | cfgV, 8'hff);
      @(negedge sys_clk);
      rxRead = 1'b1;
      @(negedge sys_clk);
      rxRead = 1'b0;
      rdReg(CFG_ADDR, 8'h07 | cfgV, 8'hff);
      waitQ();
      $display("test mode %0d done", m);
    end
    test_done();
  end
endmodule
